// ===== hdl/uhcs_core.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - in scatter/gather mode set flag bit 13 when descriptor list wraps.
// - in scatter/gather set bit 12 after three consecutive errors; never isochronous.
// - in scatter/gather set bit 11 on descriptor not ready; never isochronous.
// - in scatter/gather bits 10..3 never reach the channel interrupt.
// - crc, timeout, bit stuff or false eop set bit 7.
// - in dma mode a system bus error sets bit 2; address is readable.
// - outside scatter/gather halt on transaction error, stop request or completion.
// - in scatter/gather halt on end, bus error, excess errors, stop, babble, stall, bna.
// - done on notify descriptor (sg) or normal finish otherwise.
// - sixteen channel register sets at 0x20 stride.
// - mask bit per flag; bit 12 reserved; bus error mask only when architecture 2.
// - ping request bit 31 for out; set on in disables the channel outside scatter/gather.
// - pid bits 30:29 written by software, updated by host each packet outside scatter/gather.
// - descriptor count holds count minus one; wrap after that many descriptors.
// - in scatter/gather an eight-bit schedule gates token issue per microframe.
// - packet counter 28:19 decrements per good packet outside scatter/gather; zero means completion.
// - channel go set by software, cleared by host; halt confirms stop.
module uhcs_core #(
  parameter logic [1:0] ARCH = 2'h2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sg_mode,
  input wire logic dma_mode,
  input wire logic [3:0] ev_chan,
  input wire logic ev_is_iso,
  input wire logic ev_is_in,
  input wire logic ev_packet_ok,
  input wire logic ev_xact_err,
  input wire logic ev_bus_err,
  input wire logic [31:0] ev_bus_addr,
  input wire logic ev_desc_done,
  input wire logic ev_desc_notify,
  input wire logic ev_desc_end,
  input wire logic ev_desc_unready,
  input wire logic ev_stall,
  input wire logic ev_nak,
  input wire logic ev_ack,
  input wire logic ev_nyet,
  input wire logic ev_babble,
  input wire logic ev_overrun,
  input wire logic ev_toggle_err,
  input wire logic [2:0] uframe,
  output logic [15:0] chan_irq,
  output logic [15:0] chan_running,
  output logic [15:0] token_allow,
  output logic [1:0] next_pid
);
  import uhcs_pkg::*;

  typedef struct packed {
    logic [15:0][13:0] flags;
    logic [15:0][13:0] masks;
    logic [15:0][31:0] tsize;
    logic [15:0][31:0] dma;
    logic [15:0][1:0] xerr;
    logic [15:0][7:0] desc_idx;
    logic [15:0] go;
    logic [15:0] stop;
    logic [15:0] irq;
    logic [15:0] tok;
    logic [1:0] pid;
    uhcs_bus_t wst;
    uhcs_bus_t rst;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic bvalid;
    logic arrdy;
    logic rvalid;
  } uhcs_state_t;

  uhcs_state_t s_r, s_nxt;

  // --------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------
  // returns {hit, channel, word}; holes and foreign words leave hit low
  function automatic logic [6:0] uhcs_decode(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - UHCS_FLAGS_OFS;
    uhcs_decode = {1'b0, rel[8:5], rel[3:2]};
    if (a >= UHCS_FLAGS_OFS && rel < 12'h200 && rel[4] == 1'b0 && rel[1:0] == 2'h0) begin
      uhcs_decode[6] = 1'b1;
    end
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = st[b] ? d[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  function automatic logic [1:0] pid_toggle(input logic [1:0] p);
    pid_toggle = (p == UHCS_PID_DATA0) ? UHCS_PID_DATA1 : UHCS_PID_DATA0;
  endfunction

  // --------------------------------------------------------
  // address classification
  // --------------------------------------------------------
  logic [6:0] wdec, rdec;
  logic [3:0] wch, rch;
  logic [1:0] wsel, rsel;
  logic wok, rok, wctrl, rctrl;
  assign wdec = uhcs_decode(s_axi_awaddr);
  assign rdec = uhcs_decode(s_axi_araddr);
  assign wch = wdec[5:2];
  assign rch = rdec[5:2];
  assign wsel = wdec[1:0];
  assign rsel = rdec[1:0];
  // offsets 0x508..0x514 per channel; other words are not ours
  assign wok = wdec[6];
  assign rok = rdec[6];
  assign wctrl = s_axi_awaddr == UHCS_CTRL_OFS;
  assign rctrl = s_axi_araddr == UHCS_CTRL_OFS;

  logic wtake, rtake;
  assign wtake = s_r.awrdy && s_axi_awvalid && s_axi_wvalid;
  assign rtake = s_r.arrdy && s_axi_arvalid;

  // --------------------------------------------------------
  // next state
  // --------------------------------------------------------
  always_comb begin
    logic [13:0] setv;
    logic [13:0] eff;
    logic [13:0] wmask;
    logic [9:0] pc;
    logic [31:0] wm;
    s_nxt = s_r;
    setv = 14'h0;
    wm = 32'h0;
    eff = 14'h0;
    pc = 10'h0;
    wmask = UHCS_MASK_WMASK;
    if (ARCH != UHCS_ARCH_DMA) begin
      wmask[UHCS_B_BUSERR] = 1'b0;
    end

    // write channel: ready is a registered pulse raised once both halves wait, so both go in together
    if (s_r.wst == UHCS_IDLE && s_axi_awvalid && s_axi_wvalid && !s_r.awrdy) begin
      s_nxt.awrdy = 1'b1;
    end
    if (wtake) begin
      s_nxt.awrdy = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.wst = UHCS_RESP;
      s_nxt.bresp = UHCS_RESP_OKAY;
      if (wctrl) begin
        s_nxt.go = s_r.go | s_axi_wdata[15:0];
        s_nxt.stop = s_r.stop | (s_axi_wdata[31:16] & s_r.go);
      end else if (!wok) begin
        s_nxt.bresp = UHCS_RESP_SLVERR;
      end else begin
        case (wsel)
          2'h0: begin
            wm = wmerge(32'h0, s_axi_wdata, s_axi_wstrb);
            s_nxt.flags[wch] = s_r.flags[wch] & ~wm[13:0];
          end
          2'h1: begin
            wm = wmerge({18'h0, s_r.masks[wch]}, s_axi_wdata, s_axi_wstrb);
            s_nxt.masks[wch] = wm[13:0] & wmask;
          end
          2'h2: s_nxt.tsize[wch] = wmerge(s_r.tsize[wch], s_axi_wdata, s_axi_wstrb);
          default: s_nxt.dma[wch] = wmerge(s_r.dma[wch], s_axi_wdata, s_axi_wstrb);
        endcase
        if (wsel == 2'h2) begin
          s_nxt.desc_idx[wch] = 8'h00;
        end
      end
    end
    if (s_r.wst == UHCS_RESP && s_axi_bready) begin
      s_nxt.wst = UHCS_IDLE;
      s_nxt.bvalid = 1'b0;
    end

    // read channel, same registered ready pulse
    if (s_r.rst == UHCS_IDLE && s_axi_arvalid && !s_r.arrdy) begin
      s_nxt.arrdy = 1'b1;
    end
    if (rtake) begin
      s_nxt.arrdy = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rst = UHCS_RESP;
      s_nxt.rresp = UHCS_RESP_OKAY;
      s_nxt.rdata = 32'h0;
      if (rctrl) begin
        s_nxt.rdata = {s_r.stop, s_r.go};
      end else if (!rok) begin
        s_nxt.rresp = UHCS_RESP_SLVERR;
      end else begin
        case (rsel)
          2'h0: s_nxt.rdata = {18'h0, s_r.flags[rch]};
          2'h1: s_nxt.rdata = {18'h0, s_r.masks[rch]};
          2'h2: s_nxt.rdata = s_r.tsize[rch];
          default: s_nxt.rdata = s_r.dma[rch];
        endcase
      end
    end
    if (s_r.rst == UHCS_RESP && s_axi_rready) begin
      s_nxt.rst = UHCS_IDLE;
      s_nxt.rvalid = 1'b0;
    end

    // channel events; sets are applied after the clear so they win
    if (!sg_mode) begin
      if (s_r.tsize[ev_chan][UHCS_B_PING] && ev_is_in && s_r.go[ev_chan]) begin
        s_nxt.stop[ev_chan] = 1'b1;
      end
    end
    if (ev_xact_err) begin
      setv[UHCS_B_XACT] = 1'b1;
      if (sg_mode && !ev_is_iso) begin
        if (s_r.xerr[ev_chan] == UHCS_XERR_LIMIT - 2'h1) begin
          setv[UHCS_B_XERR] = 1'b1;
          s_nxt.xerr[ev_chan] = 2'h0;
        end else begin
          s_nxt.xerr[ev_chan] = s_r.xerr[ev_chan] + 2'h1;
        end
      end
    end else if (ev_packet_ok) begin
      s_nxt.xerr[ev_chan] = 2'h0;
    end
    setv[10] = ev_toggle_err;
    setv[9] = ev_overrun;
    setv[8] = ev_babble;
    setv[6] = ev_nyet;
    setv[5] = ev_ack;
    setv[4] = ev_nak;
    setv[3] = ev_stall;
    if (ev_bus_err && dma_mode) begin
      setv[UHCS_B_BUSERR] = 1'b1;
      s_nxt.dma[ev_chan] = ev_bus_addr;
    end
    if (sg_mode) begin
      if (ev_desc_unready && !ev_is_iso) begin
        setv[UHCS_B_BNA] = 1'b1;
      end
      if (ev_desc_done) begin
        setv[UHCS_B_DONE] = ev_desc_notify;
        if (s_r.desc_idx[ev_chan] == s_r.tsize[ev_chan][UHCS_NTD_HI:UHCS_NTD_LO]) begin
          s_nxt.desc_idx[ev_chan] = 8'h00;
          setv[UHCS_B_WRAP] = 1'b1;
        end else begin
          s_nxt.desc_idx[ev_chan] = s_r.desc_idx[ev_chan] + 8'h01;
        end
      end
      if (ev_desc_end || (ev_bus_err && dma_mode) || setv[UHCS_B_XERR]
          || ev_babble || ev_stall || setv[UHCS_B_BNA]) begin
        setv[UHCS_B_HALT] = 1'b1;
      end
    end else begin
      if (ev_packet_ok) begin
        pc = s_r.tsize[ev_chan][UHCS_PKT_HI:UHCS_PKT_LO];
        if (pc != 10'h0) begin
          pc = pc - 10'h1;
          s_nxt.tsize[ev_chan][UHCS_PKT_HI:UHCS_PKT_LO] = pc;
          s_nxt.tsize[ev_chan][UHCS_PID_HI:UHCS_PID_LO] =
            pid_toggle(s_r.tsize[ev_chan][UHCS_PID_HI:UHCS_PID_LO]);
        end
        if (pc == 10'h0) begin
          setv[UHCS_B_DONE] = 1'b1;
          setv[UHCS_B_HALT] = 1'b1;
        end
      end
      if (ev_xact_err) begin
        setv[UHCS_B_HALT] = 1'b1;
      end
    end
    s_nxt.flags[ev_chan] = s_nxt.flags[ev_chan] | setv;
    if (setv[UHCS_B_HALT]) begin
      s_nxt.go[ev_chan] = 1'b0;
      s_nxt.stop[ev_chan] = 1'b0;
    end
    // a pending stop halts its own channel, not only the one the engine reports
    for (int c = 0; c < UHCS_NCHAN; c++) begin
      if (s_r.stop[c]) begin
        s_nxt.flags[c][UHCS_B_HALT] = 1'b1;
        s_nxt.go[c] = 1'b0;
        s_nxt.stop[c] = 1'b0;
      end
    end
    s_nxt.pid = s_nxt.tsize[ev_chan][UHCS_PID_HI:UHCS_PID_LO];

    for (int c = 0; c < UHCS_NCHAN; c++) begin
      eff = s_nxt.flags[c] & s_nxt.masks[c];
      if (sg_mode) begin
        eff = eff & ~UHCS_SG_SUPPRESS;
      end
      s_nxt.irq[c] = |eff;
      s_nxt.tok[c] = s_nxt.go[c] && (!sg_mode || s_nxt.tsize[c][uframe]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.wst <= UHCS_IDLE;
      s_r.rst <= UHCS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------
  // outputs
  // --------------------------------------------------------
  assign s_axi_awready = s_r.awrdy;
  assign s_axi_wready = s_r.awrdy;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arrdy;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign chan_irq = s_r.irq;
  assign chan_running = s_r.go;
  assign token_allow = s_r.tok;
  assign next_pid = s_r.pid;

  // --------------------------------------------------------
  // checks
  // --------------------------------------------------------
  a_xact_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_xact_err |=> s_r.flags[$past(ev_chan)][UHCS_B_XACT]) else $error("transaction error flag missing");
  a_iso_no_excess: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_is_iso && !s_r.flags[ev_chan][UHCS_B_XERR] |=> !s_r.flags[$past(ev_chan)][UHCS_B_XERR])
    else $error("excess error flag on isochronous channel");
  a_sg_suppress: assert property (@(posedge aclk) disable iff (!aresetn)
    sg_mode && $stable(sg_mode) && ((s_r.flags[2] & s_r.masks[2] & ~UHCS_SG_SUPPRESS) == 14'h0)
    |-> !chan_irq[2]) else $error("suppressed flag raised irq");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    !sg_mode && $past(!sg_mode) && ((s_r.flags[2] & s_r.masks[2]) != 14'h0) |-> chan_irq[2])
    else $error("unmasked flag without irq");
  a_mask_bit12: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.masks[2][UHCS_B_XERR] == 1'b0) else $error("bit 12 mask set");
  a_halt_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_r.flags[4][UHCS_B_HALT]) |-> !chan_running[4]) else $error("halted channel still running");
  a_bus_err_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_bus_err && dma_mode |=> s_r.flags[$past(ev_chan)][UHCS_B_BUSERR]
    ##0 s_r.dma[$past(ev_chan)] == $past(ev_bus_addr))
    else $error("bus error not recorded");
  a_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn)
    wtake |=> s_axi_bvalid) else $error("write response missing");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    rtake |=> s_axi_rvalid) else $error("read response missing");
  a_wrap_only_sg: assert property (@(posedge aclk) disable iff (!aresetn)
    !sg_mode && !s_r.flags[ev_chan][UHCS_B_WRAP] |=> !s_r.flags[$past(ev_chan)][UHCS_B_WRAP])
    else $error("wrap flag outside scatter gather");
  a_pkt_done: assert property (@(posedge aclk) disable iff (!aresetn)
    !sg_mode && ev_packet_ok && s_r.tsize[ev_chan][UHCS_PKT_HI:UHCS_PKT_LO] == 10'h001
    |=> s_r.flags[$past(ev_chan)][UHCS_B_DONE]) else $error("last packet without done");
  a_stop_clears_go: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.stop != 16'h0000 |=> (s_r.go & $past(s_r.stop)) == 16'h0000) else $error("stopped channel still running");
endmodule
`default_nettype wire

// ===== hdl/uhcs_pkg.sv
package uhcs_pkg;
  localparam int unsigned UHCS_NCHAN = 16;
  localparam logic [11:0] UHCS_FLAGS_OFS = 12'h508;
  localparam logic [11:0] UHCS_MASKS_OFS = 12'h50c;
  localparam logic [11:0] UHCS_TSIZE_OFS = 12'h510;
  localparam logic [11:0] UHCS_DMA_OFS = 12'h514;
  localparam logic [11:0] UHCS_CHAN_STRIDE = 12'h020;
  localparam logic [11:0] UHCS_CTRL_OFS = 12'h900;
  localparam logic [1:0] UHCS_ARCH_DMA = 2'h2;
  localparam int unsigned UHCS_B_WRAP = 13;
  localparam int unsigned UHCS_B_XERR = 12;
  localparam int unsigned UHCS_B_BNA = 11;
  localparam int unsigned UHCS_B_XACT = 7;
  localparam int unsigned UHCS_B_BUSERR = 2;
  localparam int unsigned UHCS_B_HALT = 1;
  localparam int unsigned UHCS_B_DONE = 0;
  localparam logic [13:0] UHCS_SG_SUPPRESS = 14'h07f8;
  localparam logic [13:0] UHCS_MASK_WMASK = 14'h2fff;
  localparam logic [1:0] UHCS_XERR_LIMIT = 2'h3;
  localparam int unsigned UHCS_B_PING = 31;
  localparam int unsigned UHCS_PID_HI = 30;
  localparam int unsigned UHCS_PID_LO = 29;
  localparam int unsigned UHCS_PKT_HI = 28;
  localparam int unsigned UHCS_PKT_LO = 19;
  localparam int unsigned UHCS_NTD_HI = 15;
  localparam int unsigned UHCS_NTD_LO = 8;
  localparam logic [31:0] UHCS_RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] UHCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] UHCS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] UHCS_PID_DATA0 = 2'h0;
  localparam logic [1:0] UHCS_PID_DATA2 = 2'h1;
  localparam logic [1:0] UHCS_PID_DATA1 = 2'h2;
  localparam logic [1:0] UHCS_PID_SETUP = 2'h3;
  typedef enum logic [1:0] {
    UHCS_IDLE = 2'b01,
    UHCS_RESP = 2'b10
  } uhcs_bus_t;
endpackage

// ===== bench/uhcs_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// transaction engine stand-in
// ----------------------------------------
module uhcs_engine_model (
  input wire logic aclk,
  output logic [3:0] ev_chan,
  output logic [12:0] ev,
  output logic ev_is_iso,
  output logic [31:0] ev_bus_addr,
  output logic [2:0] uframe
);
  initial begin
    ev_chan = 4'h0;
    ev = 13'h0000;
    ev_is_iso = 1'b0;
    ev_bus_addr = 32'h0000_0000;
    uframe = 3'h0;
  end
  always @(posedge aclk) begin
    uframe <= uframe + 3'h1;
  end
  // one-cycle pulse; the address lines are driven to the inverse afterwards
  task automatic fire(input logic [3:0] ch, input int k, input logic iso, input logic [31:0] a);
    @(posedge aclk);
    ev_chan <= ch;
    ev_is_iso <= iso;
    ev_bus_addr <= a;
    ev <= 13'h0001 << k;
    @(posedge aclk);
    ev <= 13'h0000;
    ev_bus_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ===== bench/usb_host_channel_status_xfer_test.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_channel_status_xfer_test;
  import uhcs_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} uhcs_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, sg_mode = 1'b0, dma_mode = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rd_d, ev_bus_addr;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
  logic [1:0] bresp, rresp, rd_r, next_pid;
  logic [31:0] rdata;
  logic [3:0] ev_chan;
  logic [12:0] ev;
  logic ev_is_iso;
  logic [2:0] uframe;
  logic [15:0] chan_irq, chan_running, token_allow;
  int fails = 0, compares = 0;
  logic ev_is_in = 1'b0, ev_notify = 1'b0;
  logic [2:0] prev_uf = 3'h0;
  logic [7:0] sched = 8'haa;
  uhcs_row_t rows [6] = '{
    '{12'h50c, 32'hffff_ffff, 32'h0000_2fff, UHCS_RESP_OKAY},
    '{12'h6ec, 32'h0000_0004, 32'h0000_0004, UHCS_RESP_OKAY},
    '{12'h570, 32'h0010_0040, 32'h0010_0040, UHCS_RESP_OKAY},
    '{12'h5f4, 32'h1234_5670, 32'h1234_5670, UHCS_RESP_OKAY},
    '{12'h508, 32'hffff_ffff, 32'h0000_0000, UHCS_RESP_OKAY},
    '{12'h518, 32'h0000_0001, 32'h0000_0000, UHCS_RESP_SLVERR}};
  uhcs_core uhcs_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sg_mode(sg_mode),
    .dma_mode(dma_mode), .ev_chan(ev_chan), .ev_is_iso(ev_is_iso), .ev_is_in(ev_is_in),
    .ev_packet_ok(ev[0]), .ev_xact_err(ev[1]), .ev_bus_err(ev[2]), .ev_bus_addr(ev_bus_addr),
    .ev_desc_done(ev[3]), .ev_desc_notify(ev_notify), .ev_desc_end(ev[4]), .ev_desc_unready(ev[5]),
    .ev_stall(ev[6]), .ev_nak(ev[7]), .ev_ack(ev[8]), .ev_nyet(ev[9]), .ev_babble(ev[10]),
    .ev_overrun(ev[11]), .ev_toggle_err(ev[12]), .uframe(uframe), .chan_irq(chan_irq),
    .chan_running(chan_running), .token_allow(token_allow), .next_pid(next_pid));
  uhcs_engine_model uhcs_engine_model_inst (.aclk(aclk), .ev_chan(ev_chan), .ev(ev),
    .ev_is_iso(ev_is_iso), .ev_bus_addr(ev_bus_addr), .uframe(uframe));
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rd_r = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
    rd(a);
    chk(rd_d & m, x, s);
  endtask
  task automatic fire(input logic [3:0] ch, input int k, input logic iso, input int n);
    repeat (n) uhcs_engine_model_inst.fire(ch, k, iso, 32'hdead_0000);
    repeat (2) @(posedge aclk);
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    fails++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(12'h5ac, 32'hffff_ffff, 32'h0, "mask reset value");
    rchk(12'h588, 32'hffff_ffff, 32'h0, "flags reset value");
    $display("reset test done");
    // ----------------------------------------
    // register table rows
    // ----------------------------------------
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(rd_r, rows[i].r, "write response");
      rd(rows[i].a);
      chk(rd_r, rows[i].r, "read response");
      if (rows[i].r === UHCS_RESP_OKAY) chk(rd_d, rows[i].x, "read back");
    end
    $display("row test done");
    // ----------------------------------------
    // events, masking, clearing
    // ----------------------------------------
    wr(12'h54c, 32'h0000_0080);
    fire(4'h2, 1, 1'b0, 1);
    rchk(12'h548, 32'h0000_0082, 32'h0000_0082, "error sets error and halt");
    chk(chan_irq[2], 1'b1, "unmasked flag raises irq");
    sg_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(chan_irq[2], 1'b0, "sg suppresses error irq");
    sg_mode <= 1'b0;
    wr(12'h548, 32'h0000_3fff);
    rchk(12'h548, 32'hffff_ffff, 32'h0, "write one clears");
    chk(chan_irq[2], 1'b0, "irq drops after clear");
    dma_mode <= 1'b1;
    fire(4'h1, 2, 1'b0, 1);
    rchk(12'h528, 32'h0000_0004, 32'h0000_0004, "bus error flag");
    rchk(12'h534, 32'hffff_ffff, 32'hdead_0000, "failing address");
    dma_mode <= 1'b0;
    $display("event test done");
    // ----------------------------------------
    // packet count and pid
    // ----------------------------------------
    wr(12'h900, 32'h0000_0010);
    wr(12'h590, 32'h0010_0040);
    chk(chan_running[4], 1'b1, "channel go set");
    fire(4'h4, 0, 1'b0, 1);
    chk(next_pid, UHCS_PID_DATA1, "pid advances");
    rchk(12'h590, 32'h1ff8_0000, 32'h0008_0000, "packet count decrements");
    fire(4'h4, 0, 1'b0, 1);
    chk(next_pid, UHCS_PID_DATA0, "pid toggles back");
    rchk(12'h590, 32'h1ff8_0000, 32'h0, "packet count at zero");
    rchk(12'h588, 32'h0000_0003, 32'h0000_0003, "done and halt");
    $display("packet test done");
    // ----------------------------------------
    // scatter/gather error counting
    // ----------------------------------------
    sg_mode <= 1'b1;
    fire(4'h6, 1, 1'b0, 2);
    rchk(12'h5c8, 32'h0000_1000, 32'h0, "two errors are not excessive");
    fire(4'h6, 1, 1'b0, 1);
    rchk(12'h5c8, 32'h0000_1002, 32'h0000_1002, "third error excessive and halt");
    fire(4'h8, 1, 1'b1, 3);
    rchk(12'h608, 32'h0000_1000, 32'h0, "never on isochronous");
    fire(4'h9, 5, 1'b1, 1);
    rchk(12'h628, 32'h0000_0800, 32'h0, "no bna on isochronous");
    fire(4'h9, 5, 1'b0, 1);
    rchk(12'h628, 32'h0000_0802, 32'h0000_0802, "bna and halt");
    ev_notify <= 1'b1;
    wr(12'h650, 32'h0000_0100);
    fire(4'ha, 3, 1'b1, 1);
    rchk(12'h648, 32'h0000_2001, 32'h0000_0001, "notify sets done");
    fire(4'ha, 3, 1'b1, 1);
    rchk(12'h648, 32'h0000_2000, 32'h0000_2000, "list wraps after count plus one");
    ev_notify <= 1'b0;
    wr(12'h900, 32'h0000_0800);
    wr(12'h670, {24'h0, sched});
    @(posedge aclk);
    prev_uf = uframe;
    repeat (9) begin
      @(posedge aclk);
      chk(token_allow[11], sched[prev_uf], "token follows schedule");
      prev_uf = uframe;
    end
    $display("sg test done");
    // ----------------------------------------
    // channel stop paths
    // ----------------------------------------
    sg_mode <= 1'b0;
    wr(12'h900, 32'h0000_1020);
    wr(12'h5b0, 32'h8000_0000);
    ev_is_in <= 1'b1;
    fire(4'h5, 8, 1'b0, 1);
    ev_is_in <= 1'b0;
    chk(chan_running[5], 1'b0, "ping on in disables channel");
    rchk(12'h5a8, 32'h0000_0022, 32'h0000_0022, "ack and halt");
    wr(12'h900, 32'h1000_0000);
    @(posedge aclk);
    chk(chan_running[12], 1'b0, "stop request halts");
    rchk(12'h688, 32'h0000_0002, 32'h0000_0002, "halt after stop");
    $display("stop test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(12'h50c, 32'hffff_ffff, 32'h0, "masks cleared by reset");
    chk(chan_running, 16'h0000, "reset stops channels");
    $display("second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
